// ---- inc/ble_defines.svh ----
// Constants for the branch and data transfer execution block.
// Assumes one inclusion guard and plain text macro use only.
`ifndef BLE_DEFINES_SVH
`define BLE_DEFINES_SVH
// ********************
// Status flag positions
// ********************
`define BLE_FLAG_C 0
`define BLE_FLAG_Z 1
`define BLE_FLAG_N 2
`define BLE_FLAG_V 3
`define BLE_FLAG_H 5
`define BLE_FLAG_T 6
`define BLE_FLAG_I 7
// ********************
// Opcodes in bits 15:12
// ********************
`define BLE_OP_BRANCH 4'h0
`define BLE_OP_COPY 4'h1
`define BLE_OP_IMM 4'h2
`define BLE_OP_ILOAD 4'h3
`define BLE_OP_ISTORE 4'h4
`define BLE_OP_DLOAD 4'h5
`define BLE_OP_DSTORE 4'h6
`define BLE_OP_XLOAD 4'h7
`define BLE_OP_XSTORE 4'h8
// ********************
// Branch condition codes in bits 11:7
// ********************
`define BLE_CC_NE 5'h00
`define BLE_CC_CS 5'h01
`define BLE_CC_CC 5'h02
`define BLE_CC_SH 5'h03
`define BLE_CC_LO 5'h04
`define BLE_CC_MI 5'h05
`define BLE_CC_PL 5'h06
`define BLE_CC_GE 5'h07
`define BLE_CC_LT 5'h08
`define BLE_CC_HS 5'h09
`define BLE_CC_HC 5'h0a
`define BLE_CC_TS 5'h0b
`define BLE_CC_TC 5'h0c
`define BLE_CC_VS 5'h0d
`define BLE_CC_VC 5'h0e
`define BLE_CC_IE 5'h0f
`define BLE_CC_ID 5'h10
// ********************
// Pointer select and addressing mode
// ********************
`define BLE_PTR_X_LO 5'h1a
`define BLE_PTR_Y_LO 5'h1c
`define BLE_PTR_Z_LO 5'h1e
`define BLE_MODE_PLAIN 2'h0
`define BLE_MODE_POST 2'h1
`define BLE_MODE_PRE 2'h2
`define BLE_IMM_BASE 1'b1
// ********************
// Host map and reset values
// ********************
`define BLE_HOST_FLAGS 8'h20
`define BLE_HOST_PC_LO 8'h21
`define BLE_HOST_PC_HI 8'h22
`define BLE_FLAGS_RST 8'h00
`define BLE_PC_RST 16'h0000
`define BLE_REG_RST 8'h00
`endif

// ---- inc/ble_pkg.sv ----
// Types shared by the branch and data transfer execution block.
// Assumes the defines header is compiled alongside.
package ble_pkg;
  // Sequencer states
  typedef enum logic {ST_EXEC, ST_HOLD} ble_state_t;
endpackage : ble_pkg

// ---- design/ble_core.sv ----
// Branch, move, load and store execution core with its register file.
// Assumes program memory shows the words at pc and pc+1 every cycle and
// data memory returns read data in the cycle after the read strobe.
`timescale 1ns/1ps
`include "ble_defines.svh"
module ble_core (
  input wire logic clk_in, // System clock
  input wire logic reset_in, // Async reset, active high
  input wire logic run_in, // Execute when high
  input wire logic [15:0] instr_in, // Word at pc
  input wire logic [15:0] instr_ext_in, // Word at pc+1
  output logic [15:0] pc_out, // Program counter
  output logic [15:0] dmem_addr_out, // Data memory address
  output logic [7:0] dmem_wdata_out, // Data memory write data
  output logic dmem_we_out, // Data memory write strobe
  output logic dmem_re_out, // Data memory read strobe
  input wire logic [7:0] dmem_rdata_in, // Read data, cycle after strobe
  input wire logic [7:0] host_addr_in, // Host register address
  input wire logic [7:0] host_wdata_in, // Host write data
  input wire logic host_write_in, // Host write strobe
  input wire logic host_read_in, // Host read strobe
  output logic [7:0] host_rdata_out // Host read data
);
  // ********************
  // State
  // ********************
  logic [7:0] regs_q [32]; // General purpose registers
  logic [7:0] flags_q; // Status flags
  logic [15:0] pc_q; // Program counter
  ble_pkg::ble_state_t state_q; // Sequencer state
  logic [15:0] addr_q; // Data address
  logic [7:0] wdata_q; // Data to store
  logic we_q; // Store strobe
  logic re_q; // Load strobe
  logic [4:0] ld_idx_q; // Load destination
  logic wb_pend_q; // Load data arriving now
  logic [4:0] wb_idx_q; // Register for arriving data
  logic [7:0] host_rdata_q; // Host read data

  // Register value with load data forwarded; all it reads comes in as arguments,
  // so a continuous assignment that calls it wakes on every change
  function automatic logic [7:0] reg_val(input logic [4:0] idx, input logic [7:0] stored,
      input logic pend, input logic [4:0] pend_idx, input logic [7:0] pend_data);
    if (pend && (pend_idx == idx)) begin
      return pend_data;
    end
    return stored;
  endfunction : reg_val

  // Branch condition from code and flags
  function automatic logic cond_eval(input logic [4:0] cc, input logic [7:0] f);
    case (cc)
      `BLE_CC_NE: return !f[`BLE_FLAG_Z];
      `BLE_CC_CS, `BLE_CC_LO: return f[`BLE_FLAG_C];
      `BLE_CC_CC, `BLE_CC_SH: return !f[`BLE_FLAG_C];
      `BLE_CC_MI: return f[`BLE_FLAG_N];
      `BLE_CC_PL: return !f[`BLE_FLAG_N];
      `BLE_CC_GE: return !(f[`BLE_FLAG_N] ^ f[`BLE_FLAG_V]);
      `BLE_CC_LT: return f[`BLE_FLAG_N] ^ f[`BLE_FLAG_V];
      `BLE_CC_HS: return f[`BLE_FLAG_H];
      `BLE_CC_HC: return !f[`BLE_FLAG_H];
      `BLE_CC_TS: return f[`BLE_FLAG_T];
      `BLE_CC_TC: return !f[`BLE_FLAG_T];
      `BLE_CC_VS: return f[`BLE_FLAG_V];
      `BLE_CC_VC: return !f[`BLE_FLAG_V];
      `BLE_CC_IE: return f[`BLE_FLAG_I];
      `BLE_CC_ID: return !f[`BLE_FLAG_I];
      default: return 1'b0; // Unused codes never branch
    endcase
  endfunction : cond_eval

  // ********************
  // Decode
  // ********************
  wire logic [3:0] op = instr_in[15:12]; // Opcode
  wire logic exec_go = (state_q == ble_pkg::ST_EXEC) && run_in; // Executing now
  wire logic is_br = (op == `BLE_OP_BRANCH); // Conditional branch
  wire logic is_copy = (op == `BLE_OP_COPY); // Register copy
  wire logic is_imm = (op == `BLE_OP_IMM); // Immediate load
  wire logic is_ild = (op == `BLE_OP_ILOAD); // Indirect load
  wire logic is_ist = (op == `BLE_OP_ISTORE); // Indirect store
  wire logic is_dld = (op == `BLE_OP_DLOAD); // Displacement load
  wire logic is_dst = (op == `BLE_OP_DSTORE); // Displacement store
  wire logic is_xld = (op == `BLE_OP_XLOAD); // Direct load
  wire logic is_xst = (op == `BLE_OP_XSTORE); // Direct store
  wire logic is_disp = is_dld || is_dst; // Displacement form
  wire logic is_ind = is_ild || is_ist; // Pointer form
  wire logic is_load = is_ild || is_dld || is_xld; // Any load
  wire logic is_store = is_ist || is_dst || is_xst; // Any store

  // Branch target, offset sign-extended
  wire logic [6:0] br_off = instr_in[6:0]; // Signed offset
  wire logic [15:0] br_target = pc_q + {{9{br_off[6]}}, br_off} + 16'h0001;
  wire logic cond_ok = cond_eval(instr_in[11:7], flags_q); // Condition met

  // Register operands
  wire logic [4:0] reg_a = instr_in[4:0]; // Load dest or store source
  wire logic [4:0] copy_rd = instr_in[9:5]; // Copy destination
  wire logic [7:0] copy_src = reg_val(reg_a, regs_q[reg_a], wb_pend_q, wb_idx_q,
                                      dmem_rdata_in); // Copy source value
  wire logic [4:0] imm_rd = {`BLE_IMM_BASE, instr_in[11:8]}; // Upper-half dest
  wire logic [7:0] src_val = reg_val(reg_a, regs_q[reg_a], wb_pend_q, wb_idx_q,
                                     dmem_rdata_in); // Store data

  // Pointer pair selection
  wire logic [1:0] ptr_mode = instr_in[9:8]; // Addressing mode
  wire logic [4:0] ind_lo = (instr_in[11:10] == 2'h0) ? `BLE_PTR_X_LO :
                            (instr_in[11:10] == 2'h1) ? `BLE_PTR_Y_LO : `BLE_PTR_Z_LO;
  wire logic [4:0] ptr_lo = is_disp ? (instr_in[11] ? `BLE_PTR_Z_LO : `BLE_PTR_Y_LO)
                                    : ind_lo;
  wire logic [4:0] ptr_hi = {ptr_lo[4:1], 1'b1}; // High byte of pair
  wire logic [15:0] ptr_val = {
    reg_val(ptr_hi, regs_q[ptr_hi], wb_pend_q, wb_idx_q, dmem_rdata_in),
    reg_val(ptr_lo, regs_q[ptr_lo], wb_pend_q, wb_idx_q, dmem_rdata_in)}; // Pointer pair
  wire logic [15:0] ptr_inc = ptr_val + 16'h0001; // Post-increment value
  wire logic [15:0] ptr_dec = ptr_val - 16'h0001; // Pre-decrement value
  wire logic [15:0] disp_addr = ptr_val + {10'h000, instr_in[10:5]};
  wire logic is_pre = is_ind && (ptr_mode == `BLE_MODE_PRE); // Pre-decrement
  wire logic ptr_wr = exec_go && is_ind &&
                      ((ptr_mode == `BLE_MODE_POST) || is_pre);
  wire logic [15:0] ptr_new = is_pre ? ptr_dec : ptr_inc;

  // Data address for this access
  wire logic [15:0] mem_addr = (is_xld || is_xst) ? instr_ext_in :
                               is_disp ? disp_addr :
                               is_pre ? ptr_dec : ptr_val;

  // Host decode
  wire logic host_reg = (host_addr_in[7:5] == 3'h0); // Register file window
  wire logic host_wr_reg = host_write_in && host_reg; // Register write
  wire logic [4:0] host_idx = host_addr_in[4:0]; // Register addressed by host
  wire logic [7:0] host_reg_val = reg_val(host_idx, regs_q[host_idx], wb_pend_q, wb_idx_q,
                                          dmem_rdata_in); // Forwarded register value
  wire logic [7:0] host_mux = host_reg ? host_reg_val :
                              (host_addr_in == `BLE_HOST_FLAGS) ? flags_q :
                              (host_addr_in == `BLE_HOST_PC_LO) ? pc_q[7:0] :
                              (host_addr_in == `BLE_HOST_PC_HI) ? pc_q[15:8] : 8'h00;

  // ********************
  // Register file
  // ********************
  // Writes in order: load data, copy, immediate, pointer, host (last wins)
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < 32; i++) begin
        regs_q[i] <= `BLE_REG_RST;
      end
    end else begin
      if (wb_pend_q) begin
        regs_q[wb_idx_q] <= dmem_rdata_in;
      end
      if (exec_go && is_copy) begin
        regs_q[copy_rd] <= copy_src;
      end
      if (exec_go && is_imm) begin
        regs_q[imm_rd] <= instr_in[7:0];
      end
      if (ptr_wr) begin
        regs_q[ptr_lo] <= ptr_new[7:0];
        regs_q[ptr_hi] <= ptr_new[15:8];
      end
      if (host_wr_reg) begin
        regs_q[host_addr_in[4:0]] <= host_wdata_in;
      end
    end
  end

  // ********************
  // Status flags
  // ********************
  // Only the host changes flags; no instruction here touches them
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags_q <= `BLE_FLAGS_RST;
    end else if (host_write_in && (host_addr_in == `BLE_HOST_FLAGS)) begin
      flags_q <= host_wdata_in;
    end
  end

  // ********************
  // Sequencer
  // ********************
  // Two-clock forms spend a hold cycle; load data lands after it
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ble_pkg::ST_EXEC;
      pc_q <= `BLE_PC_RST;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      re_q <= 1'b0;
      ld_idx_q <= 5'h00;
      wb_pend_q <= 1'b0;
      wb_idx_q <= 5'h00;
    end else begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      wb_pend_q <= re_q; // Data is back one cycle after the strobe
      wb_idx_q <= ld_idx_q;
      case (state_q)
        ble_pkg::ST_EXEC: begin
          if (run_in) begin
            if (is_br && cond_ok) begin
              pc_q <= br_target;
              state_q <= ble_pkg::ST_HOLD;
            end else if (is_load || is_store) begin
              addr_q <= mem_addr;
              wdata_q <= src_val;
              we_q <= is_store;
              re_q <= is_load;
              ld_idx_q <= reg_a;
              pc_q <= pc_q + ((is_xld || is_xst) ? 16'h0002 : 16'h0001);
              state_q <= ble_pkg::ST_HOLD;
            end else begin
              pc_q <= pc_q + 16'h0001;
            end
          end
        end
        ble_pkg::ST_HOLD: begin
          state_q <= ble_pkg::ST_EXEC; // Second clock of the instruction
        end
        default: begin
          state_q <= ble_pkg::ST_EXEC;
        end
      endcase
      if (host_write_in && (host_addr_in == `BLE_HOST_PC_LO)) begin
        pc_q[7:0] <= host_wdata_in;
      end
      if (host_write_in && (host_addr_in == `BLE_HOST_PC_HI)) begin
        pc_q[15:8] <= host_wdata_in;
      end
    end
  end

  // ********************
  // Host read data
  // ********************
  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      host_rdata_q <= 8'h00;
    end else begin
      host_rdata_q <= host_read_in ? host_mux : 8'h00;
    end
  end

  // Outputs straight from flip-flops
  assign pc_out = pc_q;
  assign dmem_addr_out = addr_q;
  assign dmem_wdata_out = wdata_q;
  assign dmem_we_out = we_q;
  assign dmem_re_out = re_q;
  assign host_rdata_out = host_rdata_q;

  // ********************
  // Assertions
  // ********************
  wire logic no_host_pc = !(host_write_in && (host_addr_in == `BLE_HOST_PC_LO ||
                            host_addr_in == `BLE_HOST_PC_HI)); // PC not overwritten
  property p_br_taken;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && is_br && cond_ok && no_host_pc |=>
      pc_q == $past(br_target) && state_q == ble_pkg::ST_HOLD ##1 state_q == ble_pkg::ST_EXEC;
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("taken branch timing");
  property p_br_skip;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && is_br && !cond_ok && no_host_pc |=>
      pc_q == $past(pc_q) + 16'h0001 && state_q == ble_pkg::ST_EXEC;
  endproperty
  a_br_skip: assert property (p_br_skip) else $error("untaken branch timing");
  property p_cond_ne;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && is_br && instr_in[11:7] == `BLE_CC_NE && no_host_pc |=>
      pc_q == $past(pc_q) + ($past(flags_q[`BLE_FLAG_Z]) ? 16'h0001 :
        {{9{$past(instr_in[6])}}, $past(instr_in[6:0])} + 16'h0001);
  endproperty
  a_cond_ne: assert property (p_cond_ne) else $error("not-equal condition");
  property p_cond_ge;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && is_br && instr_in[11:7] == `BLE_CC_GE && no_host_pc |=>
      pc_q == $past(pc_q) + (($past(flags_q[`BLE_FLAG_N]) != $past(flags_q[`BLE_FLAG_V])) ?
        16'h0001 : {{9{$past(instr_in[6])}}, $past(instr_in[6:0])} + 16'h0001);
  endproperty
  a_cond_ge: assert property (p_cond_ge) else $error("signed ge condition");
  property p_copy;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && is_copy && !host_write_in |=>
      regs_q[$past(copy_rd)] == $past(copy_src) && $stable(flags_q);
  endproperty
  a_copy: assert property (p_copy) else $error("register copy");
  // Immediate lands in the upper-half register in one clock, flags kept
  property p_imm;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && is_imm && !host_write_in |=>
      regs_q[$past(imm_rd)] == $past(instr_in[7:0]) && $stable(flags_q) &&
      state_q == ble_pkg::ST_EXEC;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate load");
  property p_load;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && is_ild && !is_pre |=> re_q && addr_q == $past(ptr_val) ##1 wb_pend_q;
  endproperty
  a_load: assert property (p_load) else $error("indirect load");
  property p_predec;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && is_pre && !host_wr_reg |=>
      addr_q == $past(ptr_val) - 16'h0001 && {regs_q[$past(ptr_hi)], regs_q[$past(ptr_lo)]} == addr_q;
  endproperty
  a_predec: assert property (p_predec) else $error("pre-decrement");
  property p_disp;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && is_disp && !host_wr_reg && !wb_pend_q |=>
      addr_q == $past(disp_addr) && regs_q[$past(ptr_lo)] == $past(regs_q[ptr_lo]);
  endproperty
  a_disp: assert property (p_disp) else $error("displacement access");
  property p_store;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && is_store |=> we_q && !re_q && wdata_q == $past(src_val) ##1 !we_q;
  endproperty
  a_store: assert property (p_store) else $error("store strobe");
  property p_direct;
    @(posedge clk_in) disable iff (reset_in)
    exec_go && (is_xld || is_xst) && no_host_pc |=>
      addr_q == $past(instr_ext_in) && pc_q == $past(pc_q) + 16'h0002;
  endproperty
  a_direct: assert property (p_direct) else $error("direct access");
endmodule : ble_core

// ---- testbench/ble_core_tb.sv ----
// Self-checking bench for the branch and data transfer execution core.
// Assumes the defines header is on the include path; the bench plays program
// memory, data memory and the host port itself.
`timescale 1ns/1ps
`include "ble_defines.svh"
module ble_core_tb;
  // ********************
  // Signals
  // ********************
  logic clk_in; // Bench clock
  logic reset_in; // Async reset
  logic run_in; // Execute enable
  logic [15:0] instr_in, instr_ext_in, pc_out, dmem_addr_out; // Program side and data address
  logic [7:0] dmem_wdata_out, dmem_rdata_in; // Data memory side
  logic dmem_we_out, dmem_re_out; // Data strobes
  logic [7:0] host_addr_in, host_wdata_in, host_rdata_out; // Host port
  logic host_write_in, host_read_in; // Host strobes
  logic [15:0] s_pc, s_addr; // Outputs captured in the cycle after issue
  logic [7:0] s_wd; // Captured store data
  logic s_re, s_we; // Captured strobes
  logic [7:0] flv [4] = '{8'h00, 8'hff, 8'h04, 8'h08}; // Flag patterns
  logic [15:0] imm_r16 = {4'h2, 4'h0, 8'h5a}; // Marker: r16 gets 0x5a
  logic [6:0] k; // Branch offset
  logic [7:0] pa; // Pointer low register address
  logic [15:0] ea, np; // Expected address and pointer
  int mismatches, checked; // Counters

  ble_core uut (.clk_in(clk_in), .reset_in(reset_in), .run_in(run_in),
    .instr_in(instr_in), .instr_ext_in(instr_ext_in), .pc_out(pc_out),
    .dmem_addr_out(dmem_addr_out), .dmem_wdata_out(dmem_wdata_out),
    .dmem_we_out(dmem_we_out), .dmem_re_out(dmem_re_out), .dmem_rdata_in(dmem_rdata_in),
    .host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in),
    .host_write_in(host_write_in), .host_read_in(host_read_in),
    .host_rdata_out(host_rdata_out));

  // Free-running 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ********************
  // Checks and report
  // ********************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // ********************
  // Host port and execution tasks
  // ********************
  task automatic host_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    host_addr_in <= a;
    host_wdata_in <= d;
    host_write_in <= 1'b1;
    @(posedge clk_in);
    host_write_in <= 1'b0;
  endtask : host_wr

  // Read data stands only in the cycle after the strobe
  task automatic host_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    host_addr_in <= a;
    host_read_in <= 1'b1;
    @(posedge clk_in);
    host_read_in <= 1'b0;
    #1 chk16({8'h00, host_rdata_out}, {8'h00, exp});
  endtask : host_rd

  // Issue op at pc p with flags fl, offer op2 in the next cycle, answer a read
  task automatic exec_op(input logic [15:0] p, input logic [7:0] fl, input logic [15:0] op,
      input logic [15:0] ext, input logic [15:0] op2, input logic [7:0] rd);
    host_wr(8'h20, fl);
    host_wr(8'h21, p[7:0]);
    host_wr(8'h22, p[15:8]);
    @(posedge clk_in);
    instr_in <= op;
    instr_ext_in <= ext;
    run_in <= 1'b1;
    @(posedge clk_in);
    instr_in <= op2;
    #1 s_pc = pc_out;
    s_addr = dmem_addr_out;
    s_wd = dmem_wdata_out;
    s_re = dmem_re_out;
    s_we = dmem_we_out;
    @(posedge clk_in);
    run_in <= 1'b0;
    instr_in <= 16'hf000;
    dmem_rdata_in <= rd;
    @(posedge clk_in);
    dmem_rdata_in <= ~rd;
    @(posedge clk_in);
    host_rd(8'h20, fl);
  endtask : exec_op

  // Expected branch outcome from the flag byte
  function automatic logic taken(input logic [4:0] cc, input logic [7:0] f);
    case (cc)
      5'h00: taken = !f[`BLE_FLAG_Z];
      5'h01, 5'h04: taken = f[`BLE_FLAG_C];
      5'h02, 5'h03: taken = !f[`BLE_FLAG_C];
      5'h05: taken = f[`BLE_FLAG_N];
      5'h06: taken = !f[`BLE_FLAG_N];
      5'h07: taken = !(f[`BLE_FLAG_N] ^ f[`BLE_FLAG_V]);
      5'h08: taken = f[`BLE_FLAG_N] ^ f[`BLE_FLAG_V];
      5'h09: taken = f[`BLE_FLAG_H];
      5'h0a: taken = !f[`BLE_FLAG_H];
      5'h0b: taken = f[`BLE_FLAG_T];
      5'h0c: taken = !f[`BLE_FLAG_T];
      5'h0d: taken = f[`BLE_FLAG_V];
      5'h0e: taken = !f[`BLE_FLAG_V];
      5'h0f: taken = f[`BLE_FLAG_I];
      5'h10: taken = !f[`BLE_FLAG_I];
      default: taken = 1'b0; // Unused codes never branch
    endcase
  endfunction : taken

  // ********************
  // Main sequence
  // ********************
  initial begin
    mismatches = 0;
    checked = 0;
    reset_in = 1'b1;
    run_in = 1'b0;
    instr_in = 16'hf000;
    instr_ext_in = 16'h0000;
    dmem_rdata_in = 8'h00;
    host_addr_in = 8'h00;
    host_wdata_in = 8'h00;
    host_write_in = 1'b0;
    host_read_in = 1'b0;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    // Reset values and an unmapped place
    host_rd(8'h20, 8'h00);
    host_rd(8'h21, 8'h00);
    host_rd(8'h1f, 8'h00);
    host_wr(8'h40, 8'h77);
    host_rd(8'h40, 8'h00);
    // Every condition code against four flag patterns
    for (int cc = 0; cc < 18; cc++) begin
      for (int fi = 0; fi < 4; fi++) begin
        k = cc[0] ? 7'h7d : 7'h05;
        host_wr(8'h10, 8'h00);
        exec_op(16'h0100, flv[fi], {4'h0, cc[4:0], k}, 16'h0000, imm_r16, 8'h00);
        ea = taken(cc[4:0], flv[fi]) ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101;
        chk16(s_pc, ea);
        host_rd(8'h10, taken(cc[4:0], flv[fi]) ? 8'h00 : 8'h5a);
      end
    end
    // Copy followed at once by the marker, then immediate load followed by an unused opcode
    host_wr(8'h03, 8'ha5);
    host_wr(8'h10, 8'h00);
    exec_op(16'h0080, 8'h5a, {4'h1, 2'h0, 5'h07, 5'h03}, 16'h0000, imm_r16, 8'h00);
    host_rd(8'h07, 8'ha5);
    host_rd(8'h10, 8'h5a);
    exec_op(16'h0080, 8'hff, {4'h2, 4'h4, 8'h3c}, 16'h0000, 16'hf000, 8'h00);
    host_rd(8'h14, 8'h3c);
    chk16({s_pc[15:2], s_re, s_we}, 16'h0080);
    // Indirect loads and stores, every pointer code and mode, across a byte boundary
    for (int op = 3; op < 5; op++) begin
      for (int pt = 0; pt < 4; pt++) begin
        for (int md = 0; md < 4; md++) begin
          pa = (pt == 3) ? 8'h1e : 8'h1a + 8'(2 * pt);
          host_wr(pa, 8'h00);
          host_wr(pa + 8'h01, 8'h02);
          host_wr(8'h05, 8'h3e);
          host_wr(8'h10, 8'h00);
          exec_op(16'h0040, 8'ha5, {4'(op), 2'(pt), 2'(md), 3'h0, 5'h05}, 16'h0000,
            imm_r16, 8'hc9);
          ea = (md == 2) ? 16'h01ff : 16'h0200;
          np = (md == 1) ? 16'h0201 : ea;
          chk16(s_addr, ea);
          chk16({14'h0, s_re, s_we}, (op == 3) ? 16'h0002 : 16'h0001);
          chk16(s_pc, 16'h0041);
          if (op == 4) begin
            chk16({8'h00, s_wd}, 16'h003e);
          end
          host_rd(8'h05, (op == 3) ? 8'hc9 : 8'h3e);
          host_rd(pa, np[7:0]);
          host_rd(pa + 8'h01, np[15:8]);
          host_rd(8'h10, 8'h00);
        end
      end
    end
    // Displacement through both pointers at the largest offset, then direct
    for (int op = 5; op < 9; op++) begin
      for (int s = 0; s < 2; s++) begin
        pa = s ? 8'h1e : 8'h1c;
        host_wr(pa, 8'hc1);
        host_wr(pa + 8'h01, 8'h03);
        host_wr(8'h05, 8'h6b);
        exec_op(16'h0040, 8'h3c, (op > 6) ? {4'(op), 7'h00, 5'h05} :
          {4'(op), 1'(s), 6'h3f, 5'h05}, 16'h1234, 16'hf000, 8'h94);
        chk16(s_addr, (op > 6) ? 16'h1234 : 16'h0400);
        chk16(s_pc, (op > 6) ? 16'h0042 : 16'h0041);
        chk16({14'h0, s_re, s_we}, op[0] ? 16'h0002 : 16'h0001);
        if (!op[0]) begin
          chk16({8'h00, s_wd}, 16'h006b);
        end
        host_rd(8'h05, op[0] ? 8'h94 : 8'h6b);
        host_rd(pa, 8'hc1);
        host_rd(pa + 8'h01, 8'h03);
      end
    end
    wrap_up();
  end

  // Watchdog against a hung run
  initial begin
    #500000;
    mismatches++;
    wrap_up();
  end
endmodule : ble_core_tb
